// ### hw/lds_pkg.sv
// Purpose: constants, register map and helpers of the led driver serial register port
// Assumes: 16-bit frames, 7-bit address space, byte wide registers
// Notes: shared by the top module and its shifter
// Summary of operation
// RULE1: a frame with access bit one is a pure read; its data byte is ignored.
// RULE2: every transfer shifts out the status byte, then the response data byte.
// RULE3: bit counts other than a nonzero multiple of 16 drop writes, flag error.
// RULE4: seven-bit space of 128 bytes; 0x00-0x1f control, 0x20-0x7f diagnostic.
// RULE5: diagnostic registers track live inputs every cycle, with no reset value.
// RULE6: writing the input-voltage reading changes nothing and raises the link error.
// RULE7: link error flag tells whether the latest transfer was erroneous.
// RULE8: three current settings at 0x02-0x04, reset zero, fully read and write.
// RULE9: default status: vin, link error, overtemp, gate fault, gate good, reached 3..1.
// RULE10: six lit and dark voltage bytes from 0x20, alternating per channel.
// RULE11: writes to read-only registers leave them as they are and echo them.
// RULE12: frame bit 15 access type, bits 14:8 address, bits 7:0 data, msb first.
// RULE13: response is status then data of the last valid command; zero after reset.
// RULE14: sample on falling clock, drive on rising; data out released when deselected.
// RULE15: transfer spans select low; longer frames pass earlier bits on for chaining.
package lds_pkg;
   localparam int unsigned FRAME_BITS = 16;
   localparam int CNT_W = 4;
   localparam int ACC_BIT = 15;
   localparam int ADDR_HI = 14;
   localparam int ADDR_LO = 8;
   localparam int DATA_HI = 7;
   localparam logic ACC_WRITE = 1'b0;
   localparam logic [CNT_W-1:0] CNT_LAST = 4'hf;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   // register addresses
   localparam logic [6:0] A_FUNC = 7'h00;
   localparam logic [6:0] A_GATE = 7'h01;
   localparam logic [6:0] A_CUR1 = 7'h02;
   localparam logic [6:0] A_CUR2 = 7'h03;
   localparam logic [6:0] A_CUR3 = 7'h04;
   localparam logic [6:0] A_RANGE = 7'h05;
   localparam logic [6:0] A_COPY = 7'h06;
   localparam logic [6:0] A_RIP1 = 7'h0b;
   localparam logic [6:0] A_RIP2 = 7'h0c;
   localparam logic [6:0] A_RIP3 = 7'h0d;
   localparam logic [6:0] A_UVTH = 7'h0f;
   localparam logic [6:0] A_NVCMD = 7'h17;
   localparam logic [6:0] A_NVWL = 7'h18;
   localparam logic [6:0] A_NVWH = 7'h19;
   localparam logic [6:0] A_CTRL_LAST = 7'h1f;
   localparam logic [6:0] A_LIT1 = 7'h20;
   localparam logic [6:0] A_DARK1 = 7'h21;
   localparam logic [6:0] A_LIT2 = 7'h22;
   localparam logic [6:0] A_DARK2 = 7'h23;
   localparam logic [6:0] A_LIT3 = 7'h24;
   localparam logic [6:0] A_DARK3 = 7'h25;
   localparam logic [6:0] A_TEMP = 7'h26;
   localparam logic [6:0] A_NVRL = 7'h28;
   localparam logic [6:0] A_NVRH = 7'h29;
   localparam logic [6:0] A_FALLBACK = 7'h33;
   localparam logic [6:0] A_BOOT = 7'h34;
   localparam logic [6:0] A_RANGEFL = 7'h35;
   localparam logic [6:0] A_MEMFL = 7'h36;
   localparam logic [6:0] A_STATUS = 7'h37;
   localparam logic [6:0] A_VIN = 7'h38;
   // reset values
   localparam logic [7:0] R_FUNC = 8'h0e;
   localparam logic [7:0] R_GATE = 8'h96;
   localparam logic [7:0] R_RANGE = 8'h07;
   localparam logic [7:0] R_RIP = 8'h03;
   localparam logic [7:0] R_UVTH = 8'hff;
   localparam logic [7:0] R_FALLBACK = 8'h0e;
   localparam logic [7:0] R_ZERO = 8'h00;
   // implemented bits
   localparam logic [7:0] M_FUNC = 8'hce;
   localparam logic [7:0] M_FULL = 8'hff;
   localparam logic [7:0] M_LOW3 = 8'h07;
   localparam logic [7:0] M_LOW2 = 8'h03;
   localparam logic [7:0] M_NVCMD = 8'hdf;
   // status byte fields
   localparam int ST_VIN = 7;
   localparam int ST_LINK = 6;
   localparam int ST_TEMP = 5;
   localparam int ST_GFAULT = 4;
   localparam int ST_GGOOD = 3;
   // function control fields
   localparam int FC_REPORT = 7;
   localparam int FC_CLEAR = 6;
   localparam int FC_DIM_HI = 3;
   localparam int FC_DIM_LO = 1;
   // memory command fields
   localparam int NV_FETCH = 7;
   localparam int NV_STORE = 6;
   localparam int NV_ADDR_HI = 4;

   typedef enum logic [2:0]
   {
      LDS_IDLE = 3'b001,
      LDS_SHIFT = 3'b010,
      LDS_EXEC = 3'b100
   } lds_link_e;

   // writable bits of a control byte; zero means read only or absent
   function automatic logic [7:0] lds_wr_mask(input logic [6:0] addr);
      case (addr)
         A_FUNC: return M_FUNC;
         A_GATE, A_CUR1, A_CUR2, A_CUR3, A_UVTH: return M_FULL;
         A_NVWL, A_NVWH, A_FALLBACK: return M_FULL;
         A_RANGE, A_COPY: return M_LOW3;
         A_RIP1, A_RIP2, A_RIP3: return M_LOW2;
         A_NVCMD: return M_NVCMD;
         default: return R_ZERO;
      endcase
   endfunction

   function automatic logic [7:0] lds_rst_val(input logic [6:0] addr);
      case (addr)
         A_FUNC: return R_FUNC;
         A_GATE: return R_GATE;
         A_RANGE: return R_RANGE;
         A_RIP1, A_RIP2, A_RIP3: return R_RIP;
         A_UVTH: return R_UVTH;
         default: return R_ZERO;
      endcase
   endfunction
endpackage

// ### hw/lds_shifter.sv
// Purpose: frame shift register, serial output stage and bit counter
// Assumes: rise and fall are one-cycle pulses of the synchronised serial clock
// Notes: received bits push the preloaded answer out, so longer frames forward earlier ones
`timescale 1ns/1ps
module lds_shifter
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic load,
   input wire logic [lds_pkg::FRAME_BITS-1:0] load_val,
   input wire logic rise,
   input wire logic fall,
   input wire logic sdi,
   // results
   output logic [lds_pkg::FRAME_BITS-1:0] sh_q,
   output logic sdo_q,
   output logic len_ok
);
   logic [lds_pkg::CNT_W-1:0] cnt_q;
   logic whole_q;

   assign len_ok = whole_q && (cnt_q == lds_pkg::CNT_ZERO); // RULE3

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sh_q <= '0;
         cnt_q <= lds_pkg::CNT_ZERO;
         whole_q <= 1'b0;
      end
      else if (load)
      begin
         sh_q <= load_val;
         cnt_q <= lds_pkg::CNT_ZERO;
         whole_q <= 1'b0;
      end
      else if (fall)
      begin
         sh_q <= {sh_q[lds_pkg::FRAME_BITS-2:0], sdi}; // RULE14 RULE15
         cnt_q <= cnt_q + {{(lds_pkg::CNT_W-1){1'b0}}, 1'b1};
         if (cnt_q == lds_pkg::CNT_LAST)
         begin
            whole_q <= 1'b1;
         end
      end
   end

   // the first bit is presented at once so a host sampling early still sees it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sdo_q <= 1'b0;
      end
      else if (load)
      begin
         sdo_q <= load_val[lds_pkg::FRAME_BITS-1];
      end
      else if (rise)
      begin
         sdo_q <= sh_q[lds_pkg::FRAME_BITS-1]; // RULE14
      end
   end
endmodule

// ### hw/lds_sync.sv
// Purpose: two flip-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes: only the second stage is visible to the rest of the design
`timescale 1ns/1ps
module lds_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ### hw/lds_top.sv
// Purpose: serial target port and register map of a three channel led buck driver
// Assumes: clk at 100 MHz, serial clock well below a quarter of it
// Notes: pins are synchronised; commands execute in the cycle after select rises
`timescale 1ns/1ps
module lds_top
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial pins
   input wire logic select_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   // live measurements and status
   input wire logic [7:0] lit_voltage_ch1,
   input wire logic [7:0] dark_voltage_ch1,
   input wire logic [7:0] lit_voltage_ch2,
   input wire logic [7:0] dark_voltage_ch2,
   input wire logic [7:0] lit_voltage_ch3,
   input wire logic [7:0] dark_voltage_ch3,
   input wire logic [7:0] die_temp_level,
   input wire logic [7:0] memory_read_low,
   input wire logic [7:0] memory_read_high,
   input wire logic [2:0] bootstrap_low,
   input wire logic [5:0] range_low_flags,
   input wire logic [4:0] memory_pwm_flags,
   input wire logic [7:0] input_voltage_level,
   input wire logic input_voltage_stat,
   input wire logic overtemperature_flag,
   input wire logic gate_supply_fault,
   input wire logic gate_supply_good,
   input wire logic [2:0] current_reached,
   // control settings
   output logic status_report_en,
   output logic clear_errors_req,
   output logic [2:0] dimming_override,
   output logic [7:0] gate_supply_setting,
   output logic [7:0] current_setting_ch1,
   output logic [7:0] current_setting_ch2,
   output logic [7:0] current_setting_ch3,
   output logic [2:0] current_range_select,
   output logic [2:0] range_copy_pulse,
   output logic [1:0] ripple_band_ch1,
   output logic [1:0] ripple_band_ch2,
   output logic [1:0] ripple_band_ch3,
   output logic [7:0] input_low_threshold,
   // memory controls
   output logic memory_fetch_request,
   output logic memory_store_request,
   output logic [4:0] memory_address,
   output logic [7:0] nonvolatile_write_low,
   output logic [7:0] nonvolatile_write_high,
   output logic [7:0] fallback_mode_control,
   // link state
   output logic link_error_flag
);
   localparam int NCTRL = 32;

   logic [2:0] pin_s;
   logic sel_s, sclk_s, sdi_s;
   logic sel_prev_q, sclk_prev_q;
   logic sel_fall, sel_rise, sclk_rise, sclk_fall;
   lds_pkg::lds_link_e state_q, state_d;
   logic [lds_pkg::FRAME_BITS-1:0] sh_q;
   logic sdo_q, len_ok;
   logic [7:0] ctrl_q [0:NCTRL-1];
   logic [7:0] fallback_q;
   logic [7:0] resp_q;
   logic link_err_q;
   logic sdo_oe_q;
   // diagnostic copies, refreshed every cycle and never reset
   logic [7:0] lit_q [0:2];
   logic [7:0] dark_q [0:2];
   logic [7:0] temp_q, nvr_lo_q, nvr_hi_q, vin_q;
   logic [2:0] boot_q;
   logic [5:0] rfl_q;
   logic [4:0] mfl_q;
   logic [3:0] st_q;
   logic [2:0] reach_q;

   // synchronise pins; select idles high
   lds_sync #(.WIDTH(3), .RST_VAL(3'b100)) u_sync
   (
      .clk(clk),
      .rst(rst),
      .d({select_n, sclk, sdi}),
      .q(pin_s)
   );

   assign sel_s = pin_s[2];
   assign sclk_s = pin_s[1];
   assign sdi_s = pin_s[0];
   assign sel_fall = sel_prev_q && !sel_s;
   assign sel_rise = !sel_prev_q && sel_s;
   assign sclk_rise = !sel_s && sclk_s && !sclk_prev_q;
   assign sclk_fall = !sel_s && !sclk_s && sclk_prev_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sel_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         sel_prev_q <= sel_s;
         sclk_prev_q <= sclk_s;
      end
   end

   // status byte and frame fields
   logic [7:0] status_byte;
   logic acc_bit;
   logic [6:0] fr_addr;
   logic [7:0] fr_data;
   logic exec, exec_ok, exec_bad;
   logic is_ctrl, is_fallback, wr_ok, vin_write;
   logic [7:0] mask, cur_byte, merged, rd_byte;

   assign status_byte = {st_q[3], link_err_q, st_q[2:0], reach_q}; // RULE9
   assign acc_bit = sh_q[lds_pkg::ACC_BIT]; // RULE12
   assign fr_addr = sh_q[lds_pkg::ADDR_HI:lds_pkg::ADDR_LO];
   assign fr_data = sh_q[lds_pkg::DATA_HI:0];
   assign exec = (state_q == lds_pkg::LDS_EXEC);
   assign exec_ok = exec && len_ok;
   assign exec_bad = exec && !len_ok; // RULE3
   assign is_ctrl = (fr_addr <= lds_pkg::A_CTRL_LAST); // RULE4
   assign is_fallback = (fr_addr == lds_pkg::A_FALLBACK);
   assign mask = lds_pkg::lds_wr_mask(fr_addr);
   assign cur_byte = is_fallback ? fallback_q : ctrl_q[fr_addr[4:0]];
   assign merged = (cur_byte & ~mask) | (fr_data & mask);
   // a read never stores, whatever data byte came with it
   assign wr_ok = exec_ok && (acc_bit == lds_pkg::ACC_WRITE) && (is_ctrl || is_fallback); // RULE1
   assign vin_write = exec_ok && (acc_bit == lds_pkg::ACC_WRITE)
                      && (fr_addr == lds_pkg::A_VIN); // RULE6

   // read selection over the whole space; holes read as zero
   always_comb
   begin
      case (fr_addr)
         lds_pkg::A_LIT1: rd_byte = lit_q[0]; // RULE10
         lds_pkg::A_DARK1: rd_byte = dark_q[0];
         lds_pkg::A_LIT2: rd_byte = lit_q[1];
         lds_pkg::A_DARK2: rd_byte = dark_q[1];
         lds_pkg::A_LIT3: rd_byte = lit_q[2];
         lds_pkg::A_DARK3: rd_byte = dark_q[2];
         lds_pkg::A_TEMP: rd_byte = temp_q;
         lds_pkg::A_NVRL: rd_byte = nvr_lo_q;
         lds_pkg::A_NVRH: rd_byte = nvr_hi_q;
         lds_pkg::A_FALLBACK: rd_byte = fallback_q;
         lds_pkg::A_BOOT: rd_byte = {5'h00, boot_q};
         lds_pkg::A_RANGEFL: rd_byte = {2'h0, rfl_q};
         lds_pkg::A_MEMFL: rd_byte = {3'h0, mfl_q};
         lds_pkg::A_STATUS: rd_byte = status_byte;
         lds_pkg::A_VIN: rd_byte = vin_q;
         default: rd_byte = is_ctrl ? ctrl_q[fr_addr[4:0]] : lds_pkg::R_ZERO;
      endcase
   end

   // link sequencing
   always_comb
   begin
      case (state_q)
         lds_pkg::LDS_IDLE: state_d = sel_fall ? lds_pkg::LDS_SHIFT : lds_pkg::LDS_IDLE;
         lds_pkg::LDS_SHIFT: state_d = sel_rise ? lds_pkg::LDS_EXEC : lds_pkg::LDS_SHIFT;
         lds_pkg::LDS_EXEC: state_d = lds_pkg::LDS_IDLE;
         default: state_d = lds_pkg::LDS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= lds_pkg::LDS_IDLE;
      end
      else
      begin
         state_q <= state_d; // RULE15
      end
   end

   lds_shifter u_shift
   (
      .clk(clk),
      .rst(rst),
      .load(sel_fall),
      .load_val({status_byte, resp_q}), // RULE2 RULE13
      .rise(sclk_rise),
      .fall(sclk_fall),
      .sdi(sdi_s),
      .sh_q(sh_q),
      .sdo_q(sdo_q),
      .len_ok(len_ok)
   );

   // data out is driven only while selected
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sdo_oe_q <= 1'b0;
      end
      else if (sel_fall)
      begin
         sdo_oe_q <= 1'b1; // RULE14
      end
      else if (sel_rise)
      begin
         sdo_oe_q <= 1'b0;
      end
   end

   // control bytes; only implemented bits ever store
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NCTRL; i++)
         begin
            ctrl_q[i] <= lds_pkg::lds_rst_val(7'(i)); // RULE8
         end
         fallback_q <= lds_pkg::R_FALLBACK;
      end
      else if (wr_ok && is_ctrl)
      begin
         ctrl_q[fr_addr[4:0]] <= merged; // RULE8 RULE3
      end
      else if (wr_ok)
      begin
         fallback_q <= merged;
      end
   end

   // answer of the last valid command; zero after reset stands for leaving off mode
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         resp_q <= lds_pkg::R_ZERO;
      end
      else if (wr_ok)
      begin
         resp_q <= merged; // RULE13
      end
      else if (exec_ok)
      begin
         resp_q <= rd_byte; // RULE11
      end
   end

   // the flag reflects only the transfer just finished, so no separate clear exists
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         link_err_q <= 1'b0;
      end
      else if (exec)
      begin
         link_err_q <= exec_bad || vin_write; // RULE7 RULE3 RULE6
      end
   end

   always_ff @(posedge clk)
   begin
      lit_q[0] <= lit_voltage_ch1; // RULE5
      lit_q[1] <= lit_voltage_ch2;
      lit_q[2] <= lit_voltage_ch3;
      dark_q[0] <= dark_voltage_ch1;
      dark_q[1] <= dark_voltage_ch2;
      dark_q[2] <= dark_voltage_ch3;
      temp_q <= die_temp_level;
      nvr_lo_q <= memory_read_low;
      nvr_hi_q <= memory_read_high;
      vin_q <= input_voltage_level;
      boot_q <= bootstrap_low;
      rfl_q <= range_low_flags;
      mfl_q <= memory_pwm_flags;
      st_q <= {input_voltage_stat, overtemperature_flag, gate_supply_fault, gate_supply_good};
      reach_q <= current_reached;
   end

   // outputs straight from flops
   assign sdo = sdo_q;
   assign sdo_oe = sdo_oe_q;
   assign link_error_flag = link_err_q;
   assign status_report_en = ctrl_q[lds_pkg::A_FUNC[4:0]][lds_pkg::FC_REPORT];
   assign clear_errors_req = ctrl_q[lds_pkg::A_FUNC[4:0]][lds_pkg::FC_CLEAR];
   assign dimming_override = ctrl_q[lds_pkg::A_FUNC[4:0]][lds_pkg::FC_DIM_HI:lds_pkg::FC_DIM_LO];
   assign gate_supply_setting = ctrl_q[lds_pkg::A_GATE[4:0]];
   assign current_setting_ch1 = ctrl_q[lds_pkg::A_CUR1[4:0]];
   assign current_setting_ch2 = ctrl_q[lds_pkg::A_CUR2[4:0]];
   assign current_setting_ch3 = ctrl_q[lds_pkg::A_CUR3[4:0]];
   assign current_range_select = ctrl_q[lds_pkg::A_RANGE[4:0]][2:0];
   assign range_copy_pulse = ctrl_q[lds_pkg::A_COPY[4:0]][2:0];
   assign ripple_band_ch1 = ctrl_q[lds_pkg::A_RIP1[4:0]][1:0];
   assign ripple_band_ch2 = ctrl_q[lds_pkg::A_RIP2[4:0]][1:0];
   assign ripple_band_ch3 = ctrl_q[lds_pkg::A_RIP3[4:0]][1:0];
   assign input_low_threshold = ctrl_q[lds_pkg::A_UVTH[4:0]];
   assign memory_fetch_request = ctrl_q[lds_pkg::A_NVCMD[4:0]][lds_pkg::NV_FETCH];
   assign memory_store_request = ctrl_q[lds_pkg::A_NVCMD[4:0]][lds_pkg::NV_STORE];
   assign memory_address = ctrl_q[lds_pkg::A_NVCMD[4:0]][lds_pkg::NV_ADDR_HI:0];
   assign nonvolatile_write_low = ctrl_q[lds_pkg::A_NVWL[4:0]];
   assign nonvolatile_write_high = ctrl_q[lds_pkg::A_NVWH[4:0]];
   assign fallback_mode_control = fallback_q;

   // checks
   property p_bad_len;
      @(posedge clk) disable iff (rst)
      exec_bad |=> link_err_q && $stable(current_setting_ch1) && $stable(gate_supply_setting);
   endproperty
   a_bad_len: assert property (p_bad_len) else $error("bad length frame altered state"); // RULE3

   property p_vin_write;
      @(posedge clk) disable iff (rst)
      vin_write |=> link_err_q ##1 status_byte[lds_pkg::ST_LINK];
   endproperty
   a_vin_write: assert property (p_vin_write) else $error("vin write did not flag error"); // RULE6

   property p_err_clears;
      @(posedge clk) disable iff (rst)
      exec_ok && !vin_write |=> !link_err_q;
   endproperty
   a_err_clears: assert property (p_err_clears) else $error("error flag stuck"); // RULE7

   property p_cur1_write;
      @(posedge clk) disable iff (rst)
      wr_ok && fr_addr == lds_pkg::A_CUR1 |=> current_setting_ch1 == $past(fr_data);
   endproperty
   a_cur1_write: assert property (p_cur1_write) else $error("current setting not stored"); // RULE8

   property p_read_only;
      @(posedge clk) disable iff (rst)
      exec_ok && acc_bit |=> $stable(current_setting_ch2) && $stable(fallback_q);
   endproperty
   a_read_only: assert property (p_read_only) else $error("read changed a register"); // RULE1

   property p_read_resp;
      @(posedge clk) disable iff (rst)
      exec_ok && acc_bit |=> resp_q == $past(rd_byte);
   endproperty
   a_read_resp: assert property (p_read_resp) else $error("read answer wrong"); // RULE13

   property p_ro_write;
      @(posedge clk) disable iff (rst)
      exec_ok && !acc_bit && fr_addr == lds_pkg::A_DARK1 |=> resp_q == $past(dark_q[0]);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read only write not echoed"); // RULE11

   property p_load;
      @(posedge clk) disable iff (rst)
      sel_fall |=> sh_q == {$past(status_byte), $past(resp_q)} && sdo_oe ##1 sdo_oe[*2];
   endproperty
   a_load: assert property (p_load) else $error("answer not loaded on select"); // RULE2 RULE14

   property p_release;
      @(posedge clk) disable iff (rst)
      sel_rise |=> !sdo_oe ##1 exec == 1'b0;
   endproperty
   a_release: assert property (p_release) else $error("data out not released"); // RULE14 RULE15
endmodule

// ### verification/lds_host_model.sv
// Purpose: host side of the serial link, clocks frames into the port
// Assumes: link period 80 ns, select gaps of 80 ns
// Notes: frames are timed by delays, so they stay unrelated to clk
`timescale 1ns/1ps
module lds_host_model
(
   // serial pins
   output logic select_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   initial
   begin
      select_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
      rx = '0;
      select_n = 1'b0;
      #80;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi = tx[i];
         sclk = 1'b1;
         #40;
         rx = {rx[46:0], sdo};
         sclk = 1'b0;
         #40;
      end
      select_n = 1'b1;
      // a released line must not keep looking valid
      sdi = ~sdi;
      #80;
   endtask
endmodule

// ### verification/tb_top.sv
// Purpose: self-checking bench of the led driver serial register port
// Assumes: status inputs give 0x95, or 0xd5 with the link error set
// Notes: each answer carries the byte of the command before it
`timescale 1ns/1ps
module tb_top;
   logic clk, rst, sel_n, sck, mosi, sdo, sdo_oe, lerr, rep, clr, fetch, store;
   logic [7:0] lit1, m, st, gate, c1, c2, c3, uvth, nvl, nvh, fbk;
   logic [2:0] dim, rng, cpy;
   logic [1:0] r1, r2, r3;
   logic [4:0] maddr;
   logic [47:0] rx;
   logic [39:0] rows [14];
   int n_fail, samples_checked;

   // a released data out line reads inverted, so a late enable corrupts the first bit
   lds_host_model host (.select_n(sel_n), .sclk(sck), .sdi(mosi), .sdo(sdo_oe ? sdo : !sdo));
   lds_top dut (
      .clk, .rst, .select_n(sel_n), .sclk(sck), .sdi(mosi), .sdo, .sdo_oe,
      .lit_voltage_ch1(lit1), .dark_voltage_ch1(lit1 ^ 8'h66),
      .lit_voltage_ch2(m), .dark_voltage_ch2(m), .lit_voltage_ch3(m),
      .dark_voltage_ch3(m), .die_temp_level(m), .memory_read_low(m),
      .memory_read_high(m), .bootstrap_low(m[2:0]), .range_low_flags(m[5:0]),
      .memory_pwm_flags(m[4:0]), .input_voltage_level(m),
      .input_voltage_stat(st[7]), .overtemperature_flag(st[5]),
      .gate_supply_fault(st[4]), .gate_supply_good(st[3]), .current_reached(st[2:0]),
      .status_report_en(rep), .clear_errors_req(clr), .dimming_override(dim),
      .gate_supply_setting(gate), .current_setting_ch1(c1), .current_setting_ch2(c2),
      .current_setting_ch3(c3), .current_range_select(rng), .range_copy_pulse(cpy),
      .ripple_band_ch1(r1), .ripple_band_ch2(r2), .ripple_band_ch3(r3),
      .input_low_threshold(uvth), .memory_fetch_request(fetch),
      .memory_store_request(store), .memory_address(maddr),
      .nonvolatile_write_low(nvl), .nonvolatile_write_high(nvh),
      .fallback_mode_control(fbk), .link_error_flag(lerr)
   );

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic run(input int n, input logic [47:0] tx, input logic [47:0] exp);
      logic [47:0] got;
      host.xfer(n, tx, got);
      chk(got, exp);
   endtask

   task automatic defaults;
      chk({gate, c1, c2, c3, uvth, fbk}, 48'h96000000ff0e);
      chk({rep, clr, dim, rng, cpy, r1, r2, r3, lerr, sdo_oe}, 19'h1f8fc);
      chk({fetch, store, maddr, nvl, nvh}, 23'h0);
   endtask

   task automatic conclude;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // whole run is about 27 us of frames
   initial
   begin
      #200000;
      n_fail++;
      conclude();
   end

   initial
   begin
      rst = 1'b1;
      lit1 = 8'h5a;
      m = 8'h77;
      st = 8'h95;
      n_fail = 0;
      samples_checked = 0;
      rows = '{40'h5a02a59500, 40'h5a823c95a5, 40'h5a00ff95a5, 40'h11800095ce,
               40'h5aa00095ce, 40'h5a2111955a, 40'h5a8100953c, 40'h5aff009596,
               40'h5a38009500, 40'h5a8500d577, 40'h5ab7009507, 40'h5a82009595,
               40'h5a17ff95a5, 40'h5a33a595df};
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      defaults();
      foreach (rows[i])
      begin
         lit1 = rows[i][39:32];
         run(16, rows[i][31:16], rows[i][15:0]);
      end
      $display("test table done");
      host.xfer(15, 48'h0344, rx);
      chk({lerr, c2}, 9'h100);
      run(16, 48'h8300, 48'hd5a5);
      chk(lerr, 1'b0);
      run(32, 48'h82000366, 48'h95008200);
      chk({c1, c2, rep, clr, dim}, {8'ha5, 8'h66, 5'h1f});
      chk({fetch, store, maddr, fbk}, {7'h7f, 8'ha5});
      rst = 1'b1;
      @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      defaults();
      run(16, 48'h8200, 48'h9500);
      $display("test awkward done");
      conclude();
   end
endmodule
